// ---- core/halt_power_mode_control.sv ----
// halt and active-halt power mode controller with start-up delay and watchdog interplay.
// assumes wake and pending inputs are synchronous levels held until serviced, and that
// rstn_i is the system reset, so every reset is a reset wake.
//
// Implementation choices: the strobed register port and the register addresses.
`default_nettype none

module halt_power_mode_control
    import halt_pwr_pkg::*;
#(
    parameter int unsigned SHORT_CYC = STARTUP_SHORT_CYC,
    parameter int unsigned LONG_CYC  = STARTUP_LONG_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       halt_exec_i,
    input  wire logic       wdg_active_i,
    input  wire logic       time_base_irq_i,
    input  wire logic       wake_irq_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output clk_ctrl_t       clk_ctrl_o,
    output logic      [1:0] imask_level_o,
    output logic            imask_force_o,
    output logic            irq_take_o,
    output logic            vector_fetch_o,
    output logic            wdg_reset_o
);

    // ==========================================================
    // helpers
    // load value for the delay counter, option picks the long or short figure
    function automatic logic [CNT_W-1:0] delay_load(input logic long_sel);
        delay_load = long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
    endfunction

    // clock gating per state
    function automatic clk_ctrl_t clk_decode(input pwr_state_t s);
        clk_ctrl_t c;
        c = '0;
        case (s)
            ST_RUN: begin
                c = '{osc_on: 1'b1, time_base_en: 1'b1, periph_en: 1'b1, cpu_en: 1'b1};
            end
            ST_ACTIVE_HALT: begin
                c = '{osc_on: 1'b1, time_base_en: 1'b1, periph_en: 1'b0, cpu_en: 1'b0};
            end
            ST_STARTUP: begin
                c = '{osc_on: 1'b1, time_base_en: 1'b0, periph_en: 1'b0, cpu_en: 1'b0};
            end
            ST_FULL_HALT, ST_GUARD_HALT: begin
                c = '0;
            end
            default: begin
                c = '0;
            end
        endcase
        clk_decode = c;
    endfunction

    // ==========================================================
    // state
    pwr_state_t       state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             guard_reg, guard_next;     // post-wake delay still running
    logic             cause_reg, cause_next;     // 1: last wake was a reset
    logic [7:0]       ctrl_reg, ctrl_next;
    logic [7:0]       rdata_next;
    clk_ctrl_t        clk_next;
    logic             irq_take_next, vec_next, wdg_rst_next, imask_next;
    logic             osc_en, long_sel, wdg_opt, cnt_done;

    assign osc_en   = ctrl_reg[CTRL_OSC_IRQ_EN_BIT];
    assign long_sel = ctrl_reg[CTRL_LONG_DELAY_BIT];
    assign wdg_opt  = ctrl_reg[CTRL_WDG_HALT_OPT_BIT];
    assign cnt_done = (cnt_reg == '0);

    // ==========================================================
    // next-state logic
    // one counter serves both the start-up delay and the post-wake guard, they never overlap
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        guard_next    = guard_reg;
        cause_next    = cause_reg;
        irq_take_next = 1'b0;
        vec_next      = 1'b0;
        wdg_rst_next  = 1'b0;
        imask_next    = 1'b0;
        case (state_reg)
            ST_RUN: begin
                if (guard_reg) begin
                    if (cnt_done) begin
                        guard_next = 1'b0;
                    end else begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
                if (guard_reg && !cnt_done && !osc_en) begin
                    state_next = ST_GUARD_HALT;
                end else if (halt_exec_i) begin
                    if (osc_en) begin
                        state_next = ST_ACTIVE_HALT;
                        imask_next = 1'b1;
                    end else if (wdg_active_i && wdg_opt) begin
                        wdg_rst_next = 1'b1;
                    end else begin
                        state_next = ST_FULL_HALT;
                        imask_next = 1'b1;
                    end
                end
            end
            ST_ACTIVE_HALT: begin
                // levels, so a wake already pending at entry leaves on the next edge
                if (time_base_irq_i || wake_irq_i) begin
                    state_next    = ST_RUN;
                    irq_take_next = 1'b1;
                    guard_next    = 1'b1;
                    cnt_next      = delay_load(long_sel);
                    cause_next    = 1'b0;
                end
            end
            ST_FULL_HALT: begin
                if (wake_irq_i) begin
                    state_next = ST_STARTUP;
                    cnt_next   = delay_load(long_sel);
                    cause_next = 1'b0;
                end
            end
            ST_STARTUP: begin
                if (cnt_done) begin
                    state_next     = ST_RUN;
                    irq_take_next  = !cause_reg;
                    vec_next       = cause_reg;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_GUARD_HALT: begin
                // oscillator off for the rest of the guard period, then back to run
                if (cnt_done) begin
                    state_next = ST_RUN;
                    guard_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        clk_next = clk_decode(state_next);
    end

    // ==========================================================
    // register port
    // reads return zero except in the single cycle after the read strobe
    always_comb begin
        ctrl_next  = ctrl_reg;
        rdata_next = 8'h00;
        if (wr_i && (addr_i == CTRL_OFS)) begin
            ctrl_next = wdata_i & CTRL_MASK;
        end
        if (rd_i) begin
            case (addr_i)
                CTRL_OFS:   rdata_next = ctrl_reg;
                STATUS_OFS: rdata_next = {3'h0, cause_reg, guard_reg, state_reg};
                default:    rdata_next = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // registers
    // reset counts as a reset wake: start-up delay, then the reset vector
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg      <= ST_STARTUP;
            cnt_reg        <= CNT_RESET;
            guard_reg      <= 1'b0;
            cause_reg      <= 1'b1;
            ctrl_reg       <= CTRL_RESET;
            rdata_o        <= 8'h00;
            clk_ctrl_o     <= '{osc_on: 1'b1, time_base_en: 1'b0, periph_en: 1'b0, cpu_en: 1'b0};
            imask_force_o  <= 1'b0;
            irq_take_o     <= 1'b0;
            vector_fetch_o <= 1'b0;
            wdg_reset_o    <= 1'b0;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            guard_reg      <= guard_next;
            cause_reg      <= cause_next;
            ctrl_reg       <= ctrl_next;
            rdata_o        <= rdata_next;
            clk_ctrl_o     <= clk_next;
            imask_force_o  <= imask_next;
            irq_take_o     <= irq_take_next;
            vector_fetch_o <= vec_next;
            wdg_reset_o    <= wdg_rst_next;
        end
    end

    // mask level is IMASK_ENABLE only in the cycle imask_force_o pulses, zero otherwise
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            imask_level_o <= 2'h0;
        end else begin
            imask_level_o <= imask_next ? IMASK_ENABLE : 2'h0;
        end
    end

    // ==========================================================
    // checker helper
    // start-up cycles counted apart from cnt_reg, so a broken delay counter cannot
    // vouch for itself; the delay is far too long to unroll as a repetition
    logic [CNT_W:0] chk_cyc_reg, chk_cyc_next;

    // counts while in start-up, clears in every other state
    always_comb begin
        chk_cyc_next = '0;
        if (state_reg == ST_STARTUP) begin
            chk_cyc_next = chk_cyc_reg + 1'b1;
        end
    end

    // helper register, only read by the assertions
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chk_cyc_reg <= '0;
        end else begin
            chk_cyc_reg <= chk_cyc_next;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    a_active_entry: assert property (
        state_reg == ST_RUN && halt_exec_i && osc_en && !(guard_reg && !cnt_done)
        |=> state_reg == ST_ACTIVE_HALT && imask_force_o && imask_level_o == IMASK_ENABLE)
        else $error("halt with osc_irq_enable set did not enter active-halt");

    a_full_entry: assert property (
        state_reg == ST_RUN && halt_exec_i && !osc_en && !(wdg_active_i && wdg_opt)
        && !guard_reg |=> state_reg == ST_FULL_HALT && !clk_ctrl_o.osc_on)
        else $error("halt with osc_irq_enable clear did not enter full halt");

    a_active_clocks: assert property (
        state_reg == ST_ACTIVE_HALT |-> clk_ctrl_o.osc_on && clk_ctrl_o.time_base_en
        && !clk_ctrl_o.periph_en && !clk_ctrl_o.cpu_en)
        else $error("wrong clock gating in active-halt");

    a_active_stays: assert property (
        state_reg == ST_ACTIVE_HALT && !time_base_irq_i && !wake_irq_i
        |=> state_reg == ST_ACTIVE_HALT && !irq_take_o)
        else $error("active-halt left without a wake source");

    a_fast_wake: assert property (
        state_reg == ST_ACTIVE_HALT && time_base_irq_i
        |=> state_reg == ST_RUN && irq_take_o && clk_ctrl_o.cpu_en)
        else $error("interrupt wake from active-halt was delayed");

    a_short_delay: assert property (
        state_reg == ST_FULL_HALT && wake_irq_i && !long_sel && SHORT_CYC == 256
        |=> (state_reg == ST_STARTUP && !clk_ctrl_o.cpu_en)[*8] ##248 !irq_take_o ##1 irq_take_o)
        else $error("short start-up delay not 256 cycles");

    a_full_stays: assert property (
        state_reg == ST_FULL_HALT && !wake_irq_i |=> state_reg == ST_FULL_HALT)
        else $error("full halt left without a wake interrupt");

    a_wdg_reset: assert property (
        state_reg == ST_RUN && halt_exec_i && !osc_en && wdg_active_i && wdg_opt && !guard_reg
        |=> wdg_reset_o && state_reg == ST_RUN)
        else $error("watchdog halt option did not give a reset");

    a_no_wdg_active: assert property (
        state_reg == ST_RUN && halt_exec_i && osc_en |=> !wdg_reset_o)
        else $error("watchdog reset on active-halt entry");

    a_guard_fall: assert property (
        state_reg == ST_RUN && guard_reg && !cnt_done && !osc_en
        |=> state_reg == ST_GUARD_HALT && !clk_ctrl_o.osc_on)
        else $error("clearing osc_irq_enable in guard did not fall into halt");

    a_reset_vector: assert property (
        state_reg == ST_STARTUP && cnt_done && cause_reg |=> vector_fetch_o && !irq_take_o)
        else $error("reset wake did not fetch the reset vector after delay");

    a_read_ctrl: assert property (
        rd_i && addr_i == CTRL_OFS
        |=> rdata_o == $past(ctrl_reg) ##1 (rdata_o == 8'h00 || $past(rd_i)))
        else $error("control read data wrong or held");

    a_delay_len: assert property (
        state_reg == ST_STARTUP && cnt_done && !cause_reg
        |-> chk_cyc_reg == (CNT_W+1)'(SHORT_CYC - 1) || chk_cyc_reg == (CNT_W+1)'(LONG_CYC - 1))
        else $error("wake start-up delay is neither the short nor the long length");

    a_reset_delay: assert property (
        state_reg == ST_STARTUP && cnt_done && cause_reg
        |-> chk_cyc_reg == (CNT_W+1)'(CNT_RESET))
        else $error("reset start-up delay has the wrong length");

    a_startup_clocks: assert property (
        state_reg == ST_STARTUP
        |-> clk_ctrl_o.osc_on && !clk_ctrl_o.periph_en && !clk_ctrl_o.cpu_en)
        else $error("cpu or peripherals clocked during the start-up delay");

    a_halt_clocks: assert property (
        state_reg == ST_FULL_HALT || state_reg == ST_GUARD_HALT |-> clk_ctrl_o == '0)
        else $error("a clock left running in halt");

    a_guard_exit: assert property (
        state_reg == ST_GUARD_HALT && cnt_done
        |=> state_reg == ST_RUN && !guard_reg && !irq_take_o && !vector_fetch_o)
        else $error("guard halt did not return quietly to run");

    a_pend_wake: assert property (
        state_reg == ST_FULL_HALT && wake_irq_i
        |=> state_reg == ST_STARTUP && clk_ctrl_o.osc_on)
        else $error("pending wake interrupt did not leave full halt at once");

    a_mask_level: assert property (
        imask_force_o |-> imask_level_o == IMASK_ENABLE
        && (state_reg == ST_ACTIVE_HALT || state_reg == ST_FULL_HALT))
        else $error("mask forced with wrong level or outside a halt entry");

    a_one_resume: assert property (
        !(irq_take_o && vector_fetch_o))
        else $error("interrupt service and reset vector fetch at once");

    a_wdg_run: assert property (
        wdg_reset_o |-> state_reg == ST_RUN && !imask_force_o)
        else $error("watchdog reset given while entering a halt state");

    c_active_wake: cover property (state_reg == ST_ACTIVE_HALT ##1 irq_take_o);
    c_full_wake:   cover property (state_reg == ST_STARTUP && cnt_done && !cause_reg);
    c_guard_halt:  cover property (state_reg == ST_GUARD_HALT);
    c_wdg_reset:   cover property (wdg_reset_o);
    c_reset_wake:  cover property (state_reg == ST_STARTUP && cnt_done && cause_reg);

endmodule : halt_power_mode_control

`default_nettype wire

// ---- core/halt_pwr_pkg.sv ----
// package of the halt power mode controller: offsets, fields, states, carrier types.
// assumes an 8-bit register port and a cpu that pulses halt_exec_i once per halt opcode.
`default_nettype none

package halt_pwr_pkg;

    // ==========================================================
    // timing
    localparam int unsigned STARTUP_SHORT_CYC = 256;
    localparam int unsigned STARTUP_LONG_CYC  = 4096;
    localparam int unsigned CNT_W             = 13;
    localparam logic [12:0] CNT_RESET         = 13'h00FF;   // short delay minus one

    // ==========================================================
    // register map
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam int unsigned CTRL_OSC_IRQ_EN_BIT  = 0;
    localparam int unsigned CTRL_LONG_DELAY_BIT  = 1;
    localparam int unsigned CTRL_WDG_HALT_OPT_BIT = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK  = 8'h07;
    localparam logic [1:0] IMASK_ENABLE = 2'h2;             // mask level forced on halt entry
    localparam logic [7:0] HALT_OPCODE  = 8'h8E;            // for reference, decoded by the cpu

    // ==========================================================
    // states and carriers
    typedef enum logic [2:0] {
        ST_RUN         = 3'b000,
        ST_ACTIVE_HALT = 3'b001,
        ST_FULL_HALT   = 3'b010,
        ST_STARTUP     = 3'b011,
        ST_GUARD_HALT  = 3'b100
    } pwr_state_t;

    typedef struct packed {
        logic osc_on;
        logic time_base_en;
        logic periph_en;
        logic cpu_en;
    } clk_ctrl_t;

endpackage : halt_pwr_pkg

`default_nettype wire

// ---- verification/cpu_model.sv ----
// cpu stand-in for the halt controller: decodes opcodes and records taken interrupts.
// assumes the bench calls exec_op just after a rising edge of clk_sys_i.
`default_nettype none

module cpu_model
    import halt_pwr_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic irq_take_i,
    output logic      halt_exec_o,
    output var int    take_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cc_reg;
    logic [7:0] stack_q[$];

    // ==========================================================
    // quiet at time zero, so no halt before reset is released
    initial begin
        halt_exec_o = 1'b0;
        take_cnt_o  = 0;
        cc_reg      = 8'h28;
    end

    // only the halt opcode raises the one-cycle pulse
    task automatic exec_op(input logic [7:0] op);
        @(posedge clk_sys_i);
        halt_exec_o <= (op === HALT_OPCODE);
        @(posedge clk_sys_i);
        halt_exec_o <= 1'b0;
    endtask

    // ==========================================================
    // interrupt entry stacks the flags and takes routine priority
    always @(posedge clk_sys_i) begin
        if (irq_take_i === 1'b1) begin
            stack_q.push_back(cc_reg);
            cc_reg[5]  <= 1'b1;
            take_cnt_o <= take_cnt_o + 1;
        end
    end
endmodule // cpu_model

`default_nettype wire

// ---- verification/halt_power_mode_control_bench.sv ----
// self-checking bench of the halt power mode controller with a cpu model beside it.
// assumes short and long delays of 8 and 32 cycles set through the parameters.
`default_nettype none

module halt_power_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import halt_pwr_pkg::*;

`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); end end

    localparam int unsigned S_CYC = 8;
    localparam int unsigned L_CYC = 32;

    logic       clk_sys_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       halt_exec;
    logic       wdg_active_i = 1'b0;
    logic       time_base_irq_i = 1'b0;
    logic       wake_irq_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] rdata_o;
    clk_ctrl_t  clk_ctrl_o;
    logic [1:0] imask_level_o;
    logic       imask_force_o;
    logic       irq_take_o;
    logic       vector_fetch_o;
    logic       wdg_reset_o;
    int         take_cnt;
    int         n_fail = 0;
    int         checked = 0;
    int         cyc = 0;
    logic [7:0] rv;
    int         n;

    halt_power_mode_control #(.SHORT_CYC(S_CYC), .LONG_CYC(L_CYC)) uut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .halt_exec_i(halt_exec),
        .wdg_active_i(wdg_active_i), .time_base_irq_i(time_base_irq_i),
        .wake_irq_i(wake_irq_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .clk_ctrl_o(clk_ctrl_o),
        .imask_level_o(imask_level_o), .imask_force_o(imask_force_o),
        .irq_take_o(irq_take_o), .vector_fetch_o(vector_fetch_o), .wdg_reset_o(wdg_reset_o));

    cpu_model cpu (.clk_sys_i(clk_sys_i), .irq_take_i(irq_take_o),
        .halt_exec_o(halt_exec), .take_cnt_o(take_cnt));

    // ==========================================================
    // 40 MHz clock and a hang guard well above the expected run
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        rd_i <= 1'b1; addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    // bounded wait, counting edges until the taken-interrupt pulse
    task automatic wait_take(output int cnt);
        cnt = 0;
        while (irq_take_o !== 1'b1 && cnt < 300) begin
            tick();
            cnt++;
        end
    endtask

    // ==========================================================
    // reset wake: held seven edges, oscillator only, delay, then vector fetch
    task automatic t_reset();
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1;
        `CHK(clk_ctrl_o, 4'h8, "clocks in reset")
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        n = 0;
        while (vector_fetch_o !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        `CHK(vector_fetch_o, 1'b1, "vector fetch")
        `CHK(n, int'(CNT_RESET) + 1, "reset delay")
        `CHK(clk_ctrl_o, 4'hF, "run clocks")
        $display("test reset done");
    endtask

    // control keeps three bits, status read-only, holes read zero
    task automatic t_regs();
        wr(CTRL_OFS, 8'hFF);
        rd(CTRL_OFS, rv);
        `CHK(rv, 8'h07, "ctrl mask")
        wr(STATUS_OFS, 8'hFF);
        rd(STATUS_OFS, rv);
        `CHK(rv[2:0], 3'h0, "status run")
        rd(8'h10, rv);
        `CHK(rv, 8'h00, "unmapped read")
        cpu.exec_op(8'h9D);
        tick();
        `CHK(clk_ctrl_o, 4'hF, "other opcode")
        $display("test regs done");
    endtask

    // active-halt, watchdog running, time-base wake with no delay
    task automatic t_active();
        wr(CTRL_OFS, 8'h05);
        wdg_active_i <= 1'b1;
        cpu.exec_op(HALT_OPCODE);
        #1;
        `CHK(clk_ctrl_o, 4'hC, "active clocks")
        `CHK({imask_force_o, imask_level_o}, 3'h6, "mask force")
        `CHK(wdg_reset_o, 1'b0, "no watchdog reset")
        repeat (6) tick();
        `CHK(clk_ctrl_o, 4'hC, "no spurious wake")
        @(posedge clk_sys_i);
        time_base_irq_i <= 1'b1;
        tick();
        `CHK(irq_take_o, 1'b1, "take at once")
        `CHK(clk_ctrl_o, 4'hF, "run after wake")
        time_base_irq_i <= 1'b0;
        // clearing the enable inside the post-wake window falls to halt
        wr(CTRL_OFS, 8'h00);
        n = take_cnt;
        repeat (2) tick();
        `CHK(clk_ctrl_o, 4'h0, "guard halt")
        repeat (S_CYC) tick();
        `CHK(clk_ctrl_o, 4'hF, "guard over")
        `CHK(take_cnt, n, "no pulse after guard")
        wdg_active_i <= 1'b0;
        $display("test active-halt done");
    endtask

    // full halt with long delay, woken by a wake-capable interrupt
    task automatic t_full();
        wr(CTRL_OFS, 8'h02);
        cpu.exec_op(HALT_OPCODE);
        #1;
        `CHK(clk_ctrl_o, 4'h0, "full halt clocks")
        `CHK(imask_force_o, 1'b1, "mask force")
        @(posedge clk_sys_i);
        time_base_irq_i <= 1'b1;
        repeat (4) tick();
        `CHK(clk_ctrl_o, 4'h0, "time base ignored")
        time_base_irq_i <= 1'b0;
        wake_irq_i      <= 1'b1;
        tick();
        `CHK(clk_ctrl_o, 4'h8, "osc restarts")
        wait_take(n);
        `CHK(n, L_CYC, "long delay")
        wake_irq_i <= 1'b0;
        $display("test full halt done");
    endtask

    // pending wake at entry, then watchdog option giving a reset
    task automatic t_pend_wdg();
        wr(CTRL_OFS, 8'h00);
        wake_irq_i <= 1'b1;
        cpu.exec_op(HALT_OPCODE);
        #1;
        `CHK(clk_ctrl_o, 4'h0, "halt entered")
        tick();
        `CHK(clk_ctrl_o, 4'h8, "pending wakes")
        wait_take(n);
        `CHK(n, S_CYC, "short delay")
        wake_irq_i <= 1'b0;
        wr(CTRL_OFS, 8'h04);
        wdg_active_i <= 1'b1;
        cpu.exec_op(HALT_OPCODE);
        #1;
        `CHK(wdg_reset_o, 1'b1, "watchdog reset")
        `CHK(clk_ctrl_o, 4'hF, "stays running")
        wdg_active_i <= 1'b0;
        $display("test pending and watchdog done");
    endtask

    // active-halt left by a wake-capable interrupt, then by a reset while in active-halt again
    task automatic t_halt_reset();
        wr(CTRL_OFS, 8'h01);
        cpu.exec_op(HALT_OPCODE);
        @(posedge clk_sys_i);
        wake_irq_i <= 1'b1;
        tick();
        `CHK(irq_take_o, 1'b1, "wake irq exit")
        `CHK(clk_ctrl_o, 4'hF, "run after wake irq")
        wake_irq_i <= 1'b0;
        cpu.exec_op(HALT_OPCODE);
        #1;
        `CHK(clk_ctrl_o, 4'hC, "active again")
        t_reset();
        rd(CTRL_OFS, rv);
        `CHK(rv, CTRL_RESET, "ctrl after reset")
        $display("test halt reset done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    initial begin
        t_reset();
        t_regs();
        t_active();
        t_full();
        t_pend_wdg();
        t_halt_reset();
        print_verdict();
    end
endmodule // halt_power_mode_control_bench

`default_nettype wire
